// ==== hw/dsid_decoder.v ====
// Instruction decoder for a serially controlled multi-channel DAC
//
// Function
// (RL1) Data-write and read commands carry the channel address in command bits 2..0.
// (RL2) Configuration commands select channels by payload bitmask, bit n for channel n.
// (RL3) The clear command restores every register to its power-up value.
// (RL4) Software load copies preload to output register for each masked channel.
// (RL5) Write-block select sets each masked channel: 0 write-through, 1 write-block.
// (RL6) After reset all channels are in write-block mode.
// (RL7) Power-down: upper payload byte is high-impedance mask, lower byte resistor mask.
// (RL8) Both power-down bits set for a channel means resistor-to-ground power-down.
// (RL9) Both power-down masks are clear after reset.
// (RL10) Channel store writes preload in write-block mode, output in write-through mode.
// (RL11) Immediate update writes both preload and output of the addressed channel.
// (RL12) Broadcast update writes both registers of every channel.
// (RL13) The no-op command changes nothing whatever its payload.
// (RL14) Preload readback shifts the addressed preload register out during the payload.
// (RL15) Write-through updates take effect when frame select rises.
// (RL16) Serial interface and registers stay active while channels are powered down.
`include "dsid_consts.vh"

module dsid_decoder
#(
	parameter NCH = 8  // Channel count, at most 8 (mask width)
)
(
	// Clock and reset
	input  wire               sys_clk,
	input  wire               resetn,
	// Serial pins
	input  wire               spiSclk,
	input  wire               spiCsN,
	input  wire               spiMosi,
	output reg                spiMiso_ff,
	// Channel data, channel n in bits 16n+15..16n
	output reg  [16*NCH-1:0]  preloadRegister_ff,
	output reg  [16*NCH-1:0]  outputRegister_ff,
	// Channel modes
	output reg  [NCH-1:0]     writeBlockSelect_ff,
	output reg  [NCH-1:0]     powerdownHizFlag_ff,
	output reg  [NCH-1:0]     powerdownResistorFlag_ff,
	output reg  [NCH-1:0]     hizActive_ff,
	output reg  [NCH-1:0]     resistorActive_ff
);

	reg         rstMeta_ff;
	reg         rstSync_ff;
	reg  [15:0] readShift_ff;
	reg         readActive_ff;
	wire        cmdReady;
	wire        frameDone;
	wire        sclkFall;
	wire        frameActive;
	wire [7:0]  cmdByte;
	wire [15:0] payload;

	// Power-up masks held as parameters so each channel takes its own bit as a constant
	localparam [7:0] WBSEL_RST = `DSID_WBSEL_RESET;
	localparam [7:0] PD_RST    = `DSID_PD_RESET;

	////////////////////////////////////////////////////////////////////////
	// Reset release through two flops; assertion stays asynchronous
	// Every other flop of the block resets from this released copy
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
		end
		else
		begin
			rstMeta_ff <= 1'b1;
			rstSync_ff <= rstMeta_ff;
		end
	end

	// Pin timing and framing stay in the receiver; this level sees the command byte, falling-clock strobes and whole frames
	dsid_frame_rx u_rx
	(
		.sysClk         (sys_clk),
		.rstSyncN       (rstSync_ff),
		.spiSclk        (spiSclk),
		.spiCsN         (spiCsN),
		.spiMosi        (spiMosi),
		.cmdReady_ff    (cmdReady),
		.frameDone_ff   (frameDone),
		.sclkFall_ff    (sclkFall),
		.frameActive_ff (frameActive),
		.cmdByte_ff     (cmdByte),
		.payload_ff     (payload)
	);

	////////////////////////////////////////////////////////////////////////
	// Opcode test on command bits 7..3; shared by the write and read decodes
	function opcodeIs;
		input [7:0] cmd;
		input [4:0] op;
		begin
			opcodeIs = cmd[7:`DSID_OP_LSB] == op;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Command decode, only meaningful while frameDone pulses; chanAddr is also used at cmdReady for readback
	wire [2:0] chanAddr = cmdByte[`DSID_ADDR_MSB:0];          // see RL1
	// Configuration commands match the whole byte
	wire       isClear  = frameDone && cmdByte == `DSID_CMD_CLEAR;
	wire       isLoad   = frameDone && cmdByte == `DSID_CMD_LOAD;
	wire       isWbSel  = frameDone && cmdByte == `DSID_CMD_WBSEL;
	wire       isPd     = frameDone && cmdByte == `DSID_CMD_POWERDOWN;
	wire       isBcast  = frameDone && cmdByte == `DSID_CMD_BROADCAST;
	// Data writes match the opcode only; the low bits are the address
	wire       isStore  = frameDone && opcodeIs(cmdByte, `DSID_OP_STORE);
	wire       isImm    = frameDone && opcodeIs(cmdByte, `DSID_OP_IMMEDIATE);
	// No-op and reserved codes match none of the above (see RL13)

	////////////////////////////////////////////////////////////////////////
	// Per-channel registers; power-down gates nothing here (see RL16)
	// At most one decode is true in a cycle, so branch order carries no priority
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1)
		begin : gChan
			// Address compare at the genvar's width; channels above 7 are never hit
			wire hit     = {29'h0, chanAddr} == g;
			wire maskBit = payload[g];                          // see RL2
			// Channel registers change in the cycle after frameDone
			always @(posedge sys_clk or negedge rstSync_ff)
			begin
				if (!rstSync_ff)
				begin
					preloadRegister_ff[16*g +: 16] <= `DSID_DATA_RESET;
					outputRegister_ff[16*g +: 16]  <= `DSID_DATA_RESET;
					writeBlockSelect_ff[g]         <= WBSEL_RST[g];                // see RL6
					powerdownHizFlag_ff[g]         <= 1'b0;                        // see RL9
					powerdownResistorFlag_ff[g]    <= 1'b0;                        // see RL9
				end
				else if (isClear)
				begin
					// Payload ignored; same values as power-up (see RL3)
					preloadRegister_ff[16*g +: 16] <= `DSID_DATA_RESET;
					outputRegister_ff[16*g +: 16]  <= `DSID_DATA_RESET;
					writeBlockSelect_ff[g]         <= WBSEL_RST[g];
					powerdownHizFlag_ff[g]         <= PD_RST[g];
					powerdownResistorFlag_ff[g]    <= PD_RST[g];
				end
				else if (isLoad)
				begin
					// Unmasked channels keep their output
					if (maskBit)
						outputRegister_ff[16*g +: 16] <= preloadRegister_ff[16*g +: 16]; // see RL4
				end
				else if (isWbSel)
					writeBlockSelect_ff[g] <= maskBit;                                  // see RL5
				else if (isPd)
				begin
					powerdownHizFlag_ff[g]      <= payload[`DSID_HI_LSB + g];          // see RL7
					powerdownResistorFlag_ff[g] <= maskBit;                             // see RL7
				end
				else if (isBcast || (isImm && hit))
				begin
					preloadRegister_ff[16*g +: 16] <= payload;      // see RL11, see RL12
					outputRegister_ff[16*g +: 16]  <= payload;
				end
				else if (isStore && hit)
				begin
					// Write-through lands in both, so the output follows at once (see RL10)
					preloadRegister_ff[16*g +: 16] <= payload;
					if (!writeBlockSelect_ff[g])
						outputRegister_ff[16*g +: 16] <= payload;  // see RL15
				end
			end

			// Effective power-down state; resistor wins over high impedance
			// Registered so these outputs come straight from flops, one cycle late
			always @(posedge sys_clk or negedge rstSync_ff)
			begin
				if (!rstSync_ff)
				begin
					hizActive_ff[g]      <= 1'b0;
					resistorActive_ff[g] <= 1'b0;
				end
				else
				begin
					hizActive_ff[g]      <= powerdownHizFlag_ff[g] & ~powerdownResistorFlag_ff[g]; // see RL8
					resistorActive_ff[g] <= powerdownResistorFlag_ff[g];                          // see RL8
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Readback: preload loaded after the command byte, MSB first on falling clocks
	// Falling-edge shifting leaves the host half a serial period of setup
	// Miso parked low outside a frame; output register reads are not decoded
	always @(posedge sys_clk or negedge rstSync_ff)
	begin
		if (!rstSync_ff)
		begin
			readShift_ff  <= 16'h0000;
			readActive_ff <= 1'b0;
			spiMiso_ff    <= 1'b0;
		end
		else if (!frameActive)
		begin
			readActive_ff <= 1'b0;
			spiMiso_ff    <= 1'b0;
		end
		else if (cmdReady)
		begin
			readActive_ff <= opcodeIs(cmdByte, `DSID_OP_READBACK);          // see RL14
			readShift_ff  <= preloadRegister_ff[16*chanAddr +: 16];         // see RL14
		end
		else if (sclkFall && readActive_ff)
		begin
			spiMiso_ff   <= readShift_ff[15];
			readShift_ff <= {readShift_ff[14:0], 1'b0};
		end
	end

endmodule

// ==== hw/dsid_consts.vh ====
// Constants shared by the instruction decoder and its frame receiver
`ifndef DSID_CONSTS_VH
`define DSID_CONSTS_VH

// Whole command bytes
`define DSID_CMD_NOOP       8'h00
`define DSID_CMD_CLEAR      8'h01
`define DSID_CMD_LOAD       8'h18
`define DSID_CMD_WBSEL      8'h28
`define DSID_CMD_POWERDOWN  8'h30
`define DSID_CMD_BROADCAST  8'h20

// Opcodes in command bits 7..3, channel address in bits 2..0
`define DSID_OP_STORE       5'h01
`define DSID_OP_IMMEDIATE   5'h02
`define DSID_OP_READBACK    5'h11
`define DSID_ADDR_MSB       2
`define DSID_OP_LSB         3

// Payload byte positions
`define DSID_HI_MSB         15
`define DSID_HI_LSB         8
`define DSID_LO_MSB         7

// Power-up values
`define DSID_WBSEL_RESET    8'hff
`define DSID_PD_RESET       8'h00
`define DSID_DATA_RESET     16'h0000

// Frame length in serial clocks
`define DSID_CMD_BITS       5'd8
`define DSID_FRAME_BITS     5'd24
`define DSID_BITCNT_MAX     5'h1f

`endif

// ==== hw/dsid_frame_rx.v ====
// Serial frame receiver: pin synchronisers, bit counter and frame strobes
`include "dsid_consts.vh"

module dsid_frame_rx
(
	// Clock and synchronised reset
	input  wire        sysClk,
	input  wire        rstSyncN,
	// Serial pins
	input  wire        spiSclk,
	input  wire        spiCsN,
	input  wire        spiMosi,
	// Decoded frame
	output reg         cmdReady_ff,
	output reg         frameDone_ff,
	output reg         sclkFall_ff,
	output reg         frameActive_ff,
	output reg  [7:0]  cmdByte_ff,
	output reg  [15:0] payload_ff
);

	reg        sclkMeta_ff;
	reg        sclkSync_ff;
	reg        sclkPrev_ff;
	reg        csMeta_ff;
	reg        csSync_ff;
	reg        csPrev_ff;
	reg        mosiMeta_ff;
	reg        mosiSync_ff;
	reg [4:0]  bitCnt_ff;
	reg [23:0] shift_ff;

	wire sclkRise = sclkSync_ff & ~sclkPrev_ff;
	wire sclkFall = ~sclkSync_ff & sclkPrev_ff;
	wire csFall   = ~csSync_ff & csPrev_ff;
	wire csRise   = csSync_ff & ~csPrev_ff;

	////////////////////////////////////////////////////////////////////////
	// Two-stage synchronisers; only the second stage feeds any logic
	always @(posedge sysClk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			sclkMeta_ff <= 1'b0;
			sclkSync_ff <= 1'b0;
			sclkPrev_ff <= 1'b0;
			csMeta_ff   <= 1'b1;
			csSync_ff   <= 1'b1;
			csPrev_ff   <= 1'b1;
			mosiMeta_ff <= 1'b0;
			mosiSync_ff <= 1'b0;
		end
		else
		begin
			sclkMeta_ff <= spiSclk;
			sclkSync_ff <= sclkMeta_ff;
			sclkPrev_ff <= sclkSync_ff;
			csMeta_ff   <= spiCsN;
			csSync_ff   <= csMeta_ff;
			csPrev_ff   <= csSync_ff;
			mosiMeta_ff <= spiMosi;
			mosiSync_ff <= mosiMeta_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shift on rising serial clock; a frame counts only with exactly 24 bits
	always @(posedge sysClk or negedge rstSyncN)
	begin
		if (!rstSyncN)
		begin
			bitCnt_ff      <= 5'h00;
			shift_ff       <= 24'h000000;
			cmdReady_ff    <= 1'b0;
			frameDone_ff   <= 1'b0;
			sclkFall_ff    <= 1'b0;
			frameActive_ff <= 1'b0;
			cmdByte_ff     <= 8'h00;
			payload_ff     <= 16'h0000;
		end
		else
		begin
			cmdReady_ff  <= 1'b0;
			frameDone_ff <= 1'b0;
			sclkFall_ff  <= sclkFall & ~csSync_ff;
			if (csFall)
			begin
				bitCnt_ff      <= 5'h00;
				frameActive_ff <= 1'b1;
			end
			else if (!csSync_ff && sclkRise)
			begin
				shift_ff <= {shift_ff[22:0], mosiSync_ff};
				// Saturate so an overlong frame cannot wrap back to 24
				if (bitCnt_ff != `DSID_BITCNT_MAX)
					bitCnt_ff <= bitCnt_ff + 5'd1;
				if (bitCnt_ff == `DSID_CMD_BITS - 5'd1)
				begin
					cmdByte_ff  <= {shift_ff[6:0], mosiSync_ff};
					cmdReady_ff <= 1'b1;
				end
			end
			else if (csRise)
			begin
				// Completion is taken at the frame select rising edge (see RL15)
				frameActive_ff <= 1'b0;
				if (bitCnt_ff == `DSID_FRAME_BITS)
				begin
					payload_ff   <= shift_ff[15:0];
					frameDone_ff <= 1'b1;
				end
			end
		end
	end

endmodule

// ==== bench/dsid_decoder_chk.sv ====
// Port assertions for the instruction decoder
module dsid_decoder_chk
#(
	parameter NCH = 8
)
(
	// Clock, reset and serial pins
	input wire              sys_clk,
	input wire              resetn,
	input wire              spiSclk,
	input wire              spiCsN,
	input wire              spiMosi,
	input wire              spiMiso_ff,
	// Decoder state
	input wire [16*NCH-1:0] preloadRegister_ff,
	input wire [16*NCH-1:0] outputRegister_ff,
	input wire [NCH-1:0]    writeBlockSelect_ff,
	input wire [NCH-1:0]    powerdownHizFlag_ff,
	input wire [NCH-1:0]    powerdownResistorFlag_ff,
	input wire [NCH-1:0]    hizActive_ff,
	input wire [NCH-1:0]    resistorActive_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	reg       csPrev_ff;
	reg [3:0] riseAge_ff;
	////////////////////////////////////////////////////////////////
	// Cycles since frame end, saturating so long idle never wraps
	always @(posedge sys_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			csPrev_ff  <= 1'b1;
			riseAge_ff <= 4'hf;
		end
		else
		begin
			csPrev_ff <= spiCsN;
			if (spiCsN && !csPrev_ff)
				riseAge_ff <= 4'h1;
			else if (riseAge_ff != 4'hf)
				riseAge_ff <= riseAge_ff + 4'h1;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	a_pre_timing: assert property ($changed(preloadRegister_ff) |-> riseAge_ff inside {[4:6]})
		else $error("preload changed away from frame end");
	a_out_timing: assert property ($changed(outputRegister_ff) |-> riseAge_ff inside {[4:6]})
		else $error("output changed away from frame end");
	a_mode_timing: assert property ($changed(writeBlockSelect_ff) |-> riseAge_ff inside {[4:6]})
		else $error("mode changed away from frame end");
	a_hiz_timing: assert property ($changed(powerdownHizFlag_ff) |-> riseAge_ff inside {[4:6]})
		else $error("hiz flag changed away from frame end");
	a_res_timing: assert property ($changed(powerdownResistorFlag_ff) |-> riseAge_ff inside {[4:6]})
		else $error("resistor flag changed away from frame end");
	a_hiz_derive: assert property (hizActive_ff == $past(powerdownHizFlag_ff & ~powerdownResistorFlag_ff))
		else $error("hiz active wrong");
	a_res_derive: assert property ($changed(powerdownResistorFlag_ff) |=> resistorActive_ff == $past(powerdownResistorFlag_ff))
		else $error("resistor active wrong");
	a_miso_idle: assert property (spiCsN [*6] |-> !spiMiso_ff)
		else $error("miso driven outside frame");
endmodule
bind dsid_decoder dsid_decoder_chk #(.NCH(NCH)) dsid_decoder_chk_i (.sys_clk(sys_clk), .resetn(resetn),
	.spiSclk(spiSclk), .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso_ff(spiMiso_ff),
	.preloadRegister_ff(preloadRegister_ff), .outputRegister_ff(outputRegister_ff),
	.writeBlockSelect_ff(writeBlockSelect_ff), .powerdownHizFlag_ff(powerdownHizFlag_ff),
	.powerdownResistorFlag_ff(powerdownResistorFlag_ff), .hizActive_ff(hizActive_ff),
	.resistorActive_ff(resistorActive_ff));

// ==== bench/dsid_host_model.sv ====
// Serial host model driving command frames
module dsid_host_model
(
	// Pacing clock and returned data
	input  wire sysClk,
	input  wire spiMiso,
	// Serial pins
	output reg  spiSclk,
	output reg  spiCsN,
	output reg  spiMosi
);
	timeunit 1ns;
	timeprecision 1ps;
	int half = 4;
	// Idle pins; serial clock stands low between frames
	initial
	begin
		spiSclk = 1'b0;
		spiCsN  = 1'b1;
		spiMosi = 1'b0;
	end
	// Mode 0, MSB first; low phase longer so miso settles first
	task automatic xfer(input logic [23:0] word, input int nbits, output logic [15:0] rd);
		rd = 16'h0000;
		@(negedge sysClk);
		spiCsN = 1'b0;
		for (int i = 23; i > 23 - nbits; i--)
		begin
			spiMosi = word[i];
			repeat (half + 2) @(negedge sysClk);
			rd = {rd[14:0], spiMiso};
			spiSclk = 1'b1;
			repeat (half) @(negedge sysClk);
			spiSclk = 1'b0;
		end
		repeat (half) @(negedge sysClk);
		spiCsN  = 1'b1;
		spiMosi = ~spiMosi; // Released line shows no stale level
		repeat (12) @(negedge sysClk);
	endtask
endmodule

// ==== bench/dsid_decoder_bench.sv ====
// Self-checking bench for the instruction decoder
module dsid_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic         sys_clk = 1'b0;
	logic         resetn  = 1'b0;
	wire          spiSclk, spiCsN, spiMosi, spiMiso_ff;
	wire  [127:0] pre, out;
	wire  [7:0]   wbs, hiz, res, hizAct, resAct;
	logic [127:0] expPre = '0, expOut = '0;
	logic [7:0]   expWbs = 8'hff, expHiz = 8'h00, expRes = 8'h00;
	logic [15:0]  rd;
	int           num_errors = 0, checks_done = 0, cycles = 0;
	////////////////////////////////////////////////////////////////
	always #2.5 sys_clk = ~sys_clk;
	dsid_decoder #(.NCH(8)) dsid_decoder_i (.sys_clk(sys_clk), .resetn(resetn), .spiSclk(spiSclk),
		.spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso_ff(spiMiso_ff), .preloadRegister_ff(pre),
		.outputRegister_ff(out), .writeBlockSelect_ff(wbs), .powerdownHizFlag_ff(hiz),
		.powerdownResistorFlag_ff(res), .hizActive_ff(hizAct), .resistorActive_ff(resAct));
	dsid_host_model dsid_host_model_i (.sysClk(sys_clk), .spiMiso(spiMiso_ff), .spiSclk(spiSclk),
		.spiCsN(spiCsN), .spiMosi(spiMosi));
	////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Whole state compared after each frame, so stray writes show
	task automatic send(input logic [7:0] cmd, input logic [15:0] pay, input int nbits = 24);
		dsid_host_model_i.xfer({cmd, pay}, nbits, rd);
		chk("preload", expPre, pre);
		chk("output", expOut, out);
		chk("mode", {120'h0, expWbs}, {120'h0, wbs});
		chk("hizflag", {120'h0, expHiz}, {120'h0, hiz});
		chk("resflag", {120'h0, expRes}, {120'h0, res});
		chk("hizact", {120'h0, expHiz & ~expRes}, {120'h0, hizAct});
		chk("resact", {120'h0, expRes}, {120'h0, resAct});
		$display("frame %h done", cmd);
	endtask
	// Hang guard, well above the frame sequence length
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (4) @(negedge sys_clk);
		send(8'h00, 16'hffff);
		expPre[63:48] = 16'h4000;
		send(8'h0b, 16'h4000);
		expOut[63:48] = 16'h4000;
		send(8'h18, 16'h0008);
		expWbs = 8'hfe;
		send(8'h28, 16'h00fe);
		expPre[15:0] = 16'hffff;
		expOut[15:0] = 16'hffff;
		send(8'h08, 16'hffff);
		expPre[111:96] = 16'h1234;
		expOut[111:96] = 16'h1234;
		send(8'h16, 16'h1234);
		dsid_host_model_i.half = 8;
		send(8'h8e, 16'h0000);
		chk("readback", {112'h0, 16'h1234}, {112'h0, rd});
		dsid_host_model_i.half = 4;
		send(8'h0e, 16'h5555, 23);
		expHiz = 8'h03;
		expRes = 8'h01;
		send(8'h30, 16'h0301);
		send(8'h00, 16'h0000);
		expPre = {8{16'habcd}};
		expOut = {8{16'habcd}};
		send(8'h20, 16'habcd);
		expPre = '0;
		expOut = '0;
		expWbs = 8'hff;
		expHiz = 8'h00;
		expRes = 8'h00;
		send(8'h01, 16'hffff);
		end_of_test();
	end
endmodule
